// File: rtl/flash_sec_pkg.sv
// Constants for the flash security and block-protection option logic.
// What this block does
// - Reset copies nonvolatile options into working options.
// - Backdoor enable clear blocks key unlock.
// - Key writes accepted only from user firmware.
// - Eight ordered key bytes; match unlocks until reset.
// - Redirect-disable bit 1 disables vector redirection.
// - Only security code 1:0 means unsecured.
// - Secure state blocks unsecured memory access.
// - Key match or blank check forces 1:0.
// - Key-write mode steers window writes to key.
// - Reset copies nonvolatile protection; always readable.
// - Software may only shrink protect select.
// - Protect disable set freezes software protection writes.
// - Debug writes change protection without restriction.
// - Protect select sets high-end protected boundary.
// - Protected block refuses program and erase.
// - Protect disable set protects nothing.
// - Protected command ignored, violation flag set.
// - Clearing key-write mode starts key comparison.
package flash_sec_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0]  OFS_OPTIONS        = 8'h00;
  localparam logic [7:0]  OFS_CONFIG         = 8'h04;
  localparam logic [7:0]  OFS_PROTECT        = 8'h08;
  localparam logic [7:0]  OFS_STATUS         = 8'h0c;
  // ==========================================================
  // Field positions
  localparam int          BIT_BACKDOOR_EN    = 7;
  localparam int          BIT_REDIRECT_DIS   = 6;
  localparam int          BIT_KEY_WRITE_MODE = 5;
  localparam int          BIT_PROT_DISABLE   = 0;
  localparam int          BIT_PVIOL          = 5;
  localparam int          BIT_SECURE         = 0;
  localparam logic [1:0]  SEC_UNSECURED      = 2'h2;
  // ==========================================================
  // Reset values: secure and protected above 0x01ff until the copy lands
  localparam logic [7:0]  RST_OPTIONS        = 8'h00;
  localparam logic [7:0]  RST_CONFIG         = 8'h00;
  localparam logic [7:0]  RST_PROTECT        = 8'h00;
  // ==========================================================
  // Key window and flash geometry
  localparam logic [15:0] KEY_BASE           = 16'hffb0;
  localparam int          KEY_BYTES          = 8;
  localparam logic [8:0]  BLOCK_LOW_ONES     = 9'h1ff;
endpackage : flash_sec_pkg

// File: rtl/flash_security_protection_opts.sv
// Flash security options, backdoor unlock and block protection.
module flash_security_protection_opts #(
  parameter int ADDR_W = 16
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              background_debug_i,
  // Nonvolatile locations
  input  wire logic [7:0]        nv_options_location_i,
  input  wire logic [7:0]        nv_protect_location_i,
  input  wire logic [63:0]       stored_unlock_key_i,
  // Writes into flash space
  input  wire logic              fw_valid_i,
  input  wire logic [ADDR_W-1:0] fw_addr_i,
  input  wire logic [7:0]        fw_data_i,
  input  wire logic              fw_from_debug_i,
  output logic                   array_write_o,
  output logic      [ADDR_W-1:0] array_addr_o,
  output logic      [7:0]        array_data_o,
  // Command launch check
  input  wire logic              cmd_launch_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic              cmd_mass_i,
  output logic                   cmd_start_o,
  output logic                   cmd_reject_o,
  input  wire logic              blank_ok_i,
  // Memory access gate
  input  wire logic              mem_req_i,
  input  wire logic              mem_src_unsecure_i,
  output logic                   mem_deny_o,
  // Status levels
  output logic                   secure_o,
  output logic                   redirect_enable_o,
  output logic      [6:0]        protect_select_o,
  output logic                   protect_disable_o
);
  logic              load_done_reg;
  logic [7:0]        options_reg;
  logic [7:0]        config_reg;
  logic [7:0]        protect_reg;
  logic              pviol_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              compare_reg;
  logic              array_write_reg;
  logic [ADDR_W-1:0] array_addr_reg;
  logic [7:0]        array_data_reg;
  logic              cmd_start_reg;
  logic              cmd_reject_reg;
  logic              mem_deny_reg;
  logic              secure_reg;
  logic              redirect_reg;
  logic              setup;
  logic              wr_done;
  logic              sw_prot_wr;
  logic              dbg_prot_wr;
  logic              in_key_win;
  logic              cmd_prot;
  logic              unlock;
  logic [31:0]       read_mux;

  key_if key ();

  // ==========================================================
  // Helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // Protected when above the last unprotected address
  function automatic logic is_prot(input logic [7:0] p,
                                   input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] last;
    last = ADDR_W'({p[7:1], flash_sec_pkg::BLOCK_LOW_ONES});
    return !p[flash_sec_pkg::BIT_PROT_DISABLE] && a > last;
  endfunction : is_prot

  // ==========================================================
  // APB decode; zero-wait answer in the access cycle
  assign setup   = psel_i && !penable_i;
  assign wr_done = psel_i && penable_i && pready_reg && pwrite_i;

  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit(paddr_i, flash_sec_pkg::OFS_OPTIONS)) begin
      read_mux[7:0] = options_reg;
    end else if (hit(paddr_i, flash_sec_pkg::OFS_CONFIG)) begin
      read_mux[7:0] = config_reg;
    end else if (hit(paddr_i, flash_sec_pkg::OFS_PROTECT)) begin
      read_mux[7:0] = protect_reg;
    end else if (hit(paddr_i, flash_sec_pkg::OFS_STATUS)) begin
      read_mux[flash_sec_pkg::BIT_PVIOL]  = pviol_reg;
      read_mux[flash_sec_pkg::BIT_SECURE] = secure_reg;
    end
  end

  // Answer flops: data and error are ready when pready rises
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && paddr_i[7:4] != 4'h0;
      if (setup) begin
        prdata_reg <= read_mux;
      end
    end
  end

  // ==========================================================
  // Reset-time copy happens on the first edge after release
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_done_reg <= 1'b0;
    end else begin
      load_done_reg <= 1'b1;
    end
  end

  // Unlock only with the backdoor enabled; mismatch changes nothing
  assign unlock = key.match && options_reg[flash_sec_pkg::BIT_BACKDOOR_EN];

  // Working options: no software path writes this register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      options_reg <= flash_sec_pkg::RST_OPTIONS;
    end else if (!load_done_reg) begin
      options_reg <= nv_options_location_i;
    end else if (unlock || blank_ok_i) begin
      options_reg[1:0] <= flash_sec_pkg::SEC_UNSECURED;
    end
  end

  // ==========================================================
  // Configuration: key-write mode; 1->0 requests the compare
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_reg  <= flash_sec_pkg::RST_CONFIG;
      compare_reg <= 1'b0;
    end else begin
      compare_reg <= 1'b0;
      if (wr_done && hit(paddr_i, flash_sec_pkg::OFS_CONFIG)) begin
        config_reg <= {2'b00, pwdata_i[flash_sec_pkg::BIT_KEY_WRITE_MODE], 5'h00};
        compare_reg <= config_reg[flash_sec_pkg::BIT_KEY_WRITE_MODE]
                       && !pwdata_i[flash_sec_pkg::BIT_KEY_WRITE_MODE];
      end
    end
  end

  // ==========================================================
  // Protection register writes
  assign sw_prot_wr  = wr_done && hit(paddr_i, flash_sec_pkg::OFS_PROTECT)
                       && !background_debug_i;
  assign dbg_prot_wr = wr_done && hit(paddr_i, flash_sec_pkg::OFS_PROTECT)
                       && background_debug_i;

  // Software may only tighten; debug is unrestricted
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      protect_reg <= flash_sec_pkg::RST_PROTECT;
    end else if (!load_done_reg) begin
      protect_reg <= nv_protect_location_i;
    end else if (dbg_prot_wr) begin
      protect_reg <= pwdata_i[7:0];
    end else if (sw_prot_wr && !protect_reg[flash_sec_pkg::BIT_PROT_DISABLE]
                 && pwdata_i[7:1] < protect_reg[7:1]) begin
      protect_reg[7:1] <= pwdata_i[7:1];
    end
  end

  // ==========================================================
  // Flash-space writes: key bytes or array commands
  assign in_key_win = fw_addr_i[ADDR_W-1:3] == flash_sec_pkg::KEY_BASE[ADDR_W-1:3];

  // Debug-originated window writes never reach the comparator
  assign key.wr_valid   = fw_valid_i && in_key_win && !fw_from_debug_i
                          && config_reg[flash_sec_pkg::BIT_KEY_WRITE_MODE];
  assign key.wr_index   = fw_addr_i[2:0];
  assign key.wr_data    = fw_data_i;
  assign key.compare    = compare_reg;
  assign key.stored_key = stored_unlock_key_i;

  key_unlock_cmp #(
    .KEY_BYTES (flash_sec_pkg::KEY_BYTES)
  ) u_key (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .key      (key)
  );

  // Non-key writes pass on as the start of a program or erase
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      array_write_reg <= 1'b0;
      array_addr_reg  <= '0;
      array_data_reg  <= 8'h00;
    end else begin
      array_write_reg <= fw_valid_i && !(in_key_win
                         && config_reg[flash_sec_pkg::BIT_KEY_WRITE_MODE]);
      if (fw_valid_i) begin
        array_addr_reg <= fw_addr_i;
        array_data_reg <= fw_data_i;
      end
    end
  end

  // ==========================================================
  // Command launch check against the protected block
  assign cmd_prot = cmd_mass_i
                    ? is_prot(protect_reg, {ADDR_W{1'b1}})
                    : is_prot(protect_reg, cmd_addr_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_start_reg  <= 1'b0;
      cmd_reject_reg <= 1'b0;
    end else begin
      cmd_start_reg  <= cmd_launch_i && !cmd_prot;
      cmd_reject_reg <= cmd_launch_i && cmd_prot;
    end
  end

  // Violation flag: a new violation beats a same-cycle clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pviol_reg <= 1'b0;
    end else if (cmd_launch_i && cmd_prot) begin
      pviol_reg <= 1'b1;
    end else if (wr_done && hit(paddr_i, flash_sec_pkg::OFS_STATUS)
                 && pwdata_i[flash_sec_pkg::BIT_PVIOL]) begin
      pviol_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Security decode, redirection and memory gate
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      secure_reg   <= 1'b1;
      redirect_reg <= 1'b0;
      mem_deny_reg <= 1'b0;
    end else begin
      secure_reg   <= options_reg[1:0] != flash_sec_pkg::SEC_UNSECURED;
      redirect_reg <= !options_reg[flash_sec_pkg::BIT_REDIRECT_DIS];
      mem_deny_reg <= mem_req_i && mem_src_unsecure_i && secure_reg;
    end
  end

  assign prdata_o          = prdata_reg;
  assign pready_o          = pready_reg;
  assign pslverr_o         = pslverr_reg;
  assign array_write_o     = array_write_reg;
  assign array_addr_o      = array_addr_reg;
  assign array_data_o      = array_data_reg;
  assign cmd_start_o       = cmd_start_reg;
  assign cmd_reject_o      = cmd_reject_reg;
  assign mem_deny_o        = mem_deny_reg;
  assign secure_o          = secure_reg;
  assign redirect_enable_o = redirect_reg;
  assign protect_select_o  = protect_reg[7:1];
  assign protect_disable_o = protect_reg[flash_sec_pkg::BIT_PROT_DISABLE];

  // ==========================================================
  // Checks
  property p_opt_load;
    @(posedge clk_i) disable iff (!resetn_i)
      !load_done_reg |=> options_reg == $past(nv_options_location_i);
  endproperty
  a_opt_load: assert property (p_opt_load)
    else $error("options not copied at reset");

  property p_prot_load;
    @(posedge clk_i) disable iff (!resetn_i)
      !load_done_reg |=> protect_reg == $past(nv_protect_location_i);
  endproperty
  a_prot_load: assert property (p_prot_load)
    else $error("protection not copied at reset");

  property p_no_backdoor;
    @(posedge clk_i) disable iff (!resetn_i)
      load_done_reg && key.match && !options_reg[flash_sec_pkg::BIT_BACKDOOR_EN] && !blank_ok_i
      |=> $stable(options_reg);
  endproperty
  a_no_backdoor: assert property (p_no_backdoor)
    else $error("unlock with backdoor disabled");

  property p_unlock;
    @(posedge clk_i) disable iff (!resetn_i)
      load_done_reg && (unlock || blank_ok_i)
      |=> options_reg[1:0] == flash_sec_pkg::SEC_UNSECURED ##1 !secure_o;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("security not lifted after unlock");

  property p_secure_decode;
    @(posedge clk_i) disable iff (!resetn_i)
      1'b1 |=> secure_o == ($past(options_reg[1:0]) != flash_sec_pkg::SEC_UNSECURED);
  endproperty
  a_secure_decode: assert property (p_secure_decode)
    else $error("security decode wrong");

  property p_redirect;
    @(posedge clk_i) disable iff (!resetn_i)
      1'b1 |=> redirect_enable_o == !$past(options_reg[flash_sec_pkg::BIT_REDIRECT_DIS]);
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("redirection does not follow option bit");

  property p_sw_no_loosen;
    @(posedge clk_i) disable iff (!resetn_i)
      load_done_reg && sw_prot_wr
      && (protect_reg[flash_sec_pkg::BIT_PROT_DISABLE] || pwdata_i[7:1] >= protect_reg[7:1])
      |=> $stable(protect_reg);
  endproperty
  a_sw_no_loosen: assert property (p_sw_no_loosen)
    else $error("software loosened protection");

  property p_dbg_write;
    @(posedge clk_i) disable iff (!resetn_i)
      load_done_reg && dbg_prot_wr |=> protect_reg == $past(pwdata_i[7:0]);
  endproperty
  a_dbg_write: assert property (p_dbg_write)
    else $error("debug protection write lost");

  sequence s_bad_launch;
    cmd_launch_i && cmd_prot;
  endsequence
  sequence s_refused;
    cmd_reject_o && !cmd_start_o && pviol_reg;
  endsequence
  property p_violation;
    @(posedge clk_i) disable iff (!resetn_i)
      s_bad_launch |=> s_refused;
  endproperty
  a_violation: assert property (p_violation)
    else $error("protected command not refused");

  property p_mem_gate;
    @(posedge clk_i) disable iff (!resetn_i)
      mem_req_i && mem_src_unsecure_i && secure_o |=> mem_deny_o;
  endproperty
  a_mem_gate: assert property (p_mem_gate)
    else $error("unsecured access not blocked");

  sequence s_key_exit;
    wr_done && hit(paddr_i, flash_sec_pkg::OFS_CONFIG)
    && config_reg[flash_sec_pkg::BIT_KEY_WRITE_MODE] && !pwdata_i[flash_sec_pkg::BIT_KEY_WRITE_MODE];
  endsequence
  property p_compare_start;
    @(posedge clk_i) disable iff (!resetn_i)
      s_key_exit |=> compare_reg;
  endproperty
  a_compare_start: assert property (p_compare_start)
    else $error("compare not started on key mode exit");
endmodule : flash_security_protection_opts

// File: rtl/key_if.sv
// Carrier between the option logic and the key comparator.
interface key_if;
  logic        wr_valid;
  logic [2:0]  wr_index;
  logic [7:0]  wr_data;
  logic        compare;
  logic [63:0] stored_key;
  logic        match;
  modport host   (output wr_valid, wr_index, wr_data, compare, stored_key,
                  input  match);
  modport engine (input  wr_valid, wr_index, wr_data, compare, stored_key,
                  output match);
endinterface : key_if

// File: rtl/key_unlock_cmp.sv
// Backdoor key capture and comparison engine.
module key_unlock_cmp #(
  parameter int KEY_BYTES = flash_sec_pkg::KEY_BYTES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  key_if.engine    key
);
  localparam int CW = $clog2(KEY_BYTES + 1);

  logic [7:0]    entered_reg [KEY_BYTES];
  logic [CW-1:0] count_reg;
  logic          order_ok_reg;
  logic          match_reg;
  logic          all_eq;

  // ==========================================================
  // Capture entered bytes by position
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < KEY_BYTES; i++) begin
        entered_reg[i] <= 8'h00;
      end
    end else if (key.wr_valid) begin
      entered_reg[key.wr_index] <= key.wr_data;
    end
  end

  // Track first-to-last order; any skip or repeat spoils the attempt
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_reg    <= '0;
      order_ok_reg <= 1'b1;
    end else if (key.compare) begin
      count_reg    <= '0;
      order_ok_reg <= 1'b1;
    end else if (key.wr_valid) begin
      if (count_reg == CW'(KEY_BYTES) || CW'(key.wr_index) != count_reg) begin
        order_ok_reg <= 1'b0;
      end
      if (count_reg != CW'(KEY_BYTES)) begin
        count_reg <= count_reg + CW'(1);
      end
    end
  end

  // Byte i of the stored key sits at bits 8*i+7..8*i
  always_comb begin
    all_eq = 1'b1;
    for (int i = 0; i < KEY_BYTES; i++) begin
      if (entered_reg[i] != key.stored_key[8*i +: 8]) begin
        all_eq = 1'b0;
      end
    end
  end

  // One-cycle match verdict after each compare request
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= key.compare && order_ok_reg && all_eq
                   && count_reg == CW'(KEY_BYTES);
    end
  end

  assign key.match = match_reg;

  property p_match_cause;
    @(posedge clk_i) disable iff (!resetn_i)
      key.match |-> $past(key.compare) && $past(count_reg) == CW'(KEY_BYTES);
  endproperty
  a_match_cause: assert property (p_match_cause)
    else $error("key match without full ordered entry");
endmodule : key_unlock_cmp

// File: tb/fw_host_model.sv
// Firmware-side model that writes flash space and launches commands.
module fw_host_model (
  input  wire logic   clk_i,
  output logic        fw_valid_o,
  output logic [15:0] fw_addr_o,
  output logic [7:0]  fw_data_o,
  output logic        fw_from_debug_o,
  output logic        cmd_launch_o,
  output logic [15:0] cmd_addr_o,
  output logic        cmd_mass_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Idle state
  initial begin
    fw_valid_o = 1'b0;
    fw_addr_o = 16'h0000;
    fw_data_o = 8'h00;
    fw_from_debug_o = 1'b0;
    cmd_launch_o = 1'b0;
    cmd_addr_o = 16'h0000;
    cmd_mass_o = 1'b0;
  end
  // Bytes go first to eighth with an idle cycle between them, as key
  // writes may not sit on adjacent bus cycles; released lines flip
  task automatic send_key(input logic [63:0] k, input logic dbg);
    for (int i = 0; i < 8; i++) begin
      fw_valid_o <= 1'b1;
      fw_addr_o <= 16'hffb0 + 16'(i);
      fw_data_o <= k[8*i+:8];
      fw_from_debug_o <= dbg;
      @(posedge clk_i);
      fw_valid_o <= 1'b0;
      fw_addr_o <= ~fw_addr_o;
      fw_data_o <= ~fw_data_o;
      @(posedge clk_i);
    end
  endtask : send_key
  // One-cycle command launch
  task automatic launch(input logic [15:0] a, input logic m);
    cmd_launch_o <= 1'b1;
    cmd_addr_o <= a;
    cmd_mass_o <= m;
    @(posedge clk_i);
    cmd_launch_o <= 1'b0;
    cmd_addr_o <= ~a;
  endtask : launch
endmodule : fw_host_model

// File: tb/tb_flash_security_protection_opts.sv
// Self-checking bench for the flash security and protection logic.
module tb_flash_security_protection_opts;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
  logic clk, resetn, psel, penable, pwrite, dbg, blank_ok, mem_req, mem_unsec;
  logic [7:0] paddr, nv_opt, nv_prot, ad, adat;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, fv, fdbg, cl, cm, aw, cs, cr, deny, sec, redir, pdis;
  logic [15:0] fa, ca, aa;
  logic [6:0] psel7;
  int fail_count, checks, aw_cnt;
  fw_host_model u_fw (.clk_i(clk), .fw_valid_o(fv), .fw_addr_o(fa), .fw_data_o(ad),
    .fw_from_debug_o(fdbg), .cmd_launch_o(cl), .cmd_addr_o(ca), .cmd_mass_o(cm));
  flash_security_protection_opts u_dut (.clk_i(clk), .resetn_i(resetn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .background_debug_i(dbg),
    .nv_options_location_i(nv_opt), .nv_protect_location_i(nv_prot),
    .stored_unlock_key_i(KEY), .fw_valid_i(fv), .fw_addr_i(fa), .fw_data_i(ad),
    .fw_from_debug_i(fdbg), .array_write_o(aw), .array_addr_o(aa), .array_data_o(adat),
    .cmd_launch_i(cl), .cmd_addr_i(ca), .cmd_mass_i(cm), .cmd_start_o(cs),
    .cmd_reject_o(cr), .blank_ok_i(blank_ok), .mem_req_i(mem_req),
    .mem_src_unsecure_i(mem_unsec), .mem_deny_o(deny), .secure_o(sec),
    .redirect_enable_o(redir), .protect_select_o(psel7), .protect_disable_o(pdis));
  // ==========================================
  // Clock, array write counter and watchdog
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    if (aw === 1'b1) aw_cnt++;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
  // ==========================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // APB transfer; pready is sampled at each rising edge of the access
  // phase, and the request is only released at the edge that takes it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic dg);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    dbg <= dg;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    dbg <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // Key entry then clearing the mode bit starts the compare
  task automatic key_try(input logic [63:0] k, input logic dg);
    apb(1, 8'h04, 32'h0000_0020, 0);
    u_fw.send_key(k, dg);
    apb(1, 8'h04, 32'h0000_0000, 0);
    repeat (5) @(posedge clk);
  endtask : key_try
  task automatic cmd(input logic [15:0] a, input logic m, input logic es, input logic er);
    u_fw.launch(a, m);
    @(negedge clk);
    chk("cmd_start", 32'(cs), 32'(es));
    chk("cmd_reject", 32'(cr), 32'(er));
    @(posedge clk);
  endtask : cmd
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Test sequence
  initial begin
    clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    dbg = 0; blank_ok = 0; mem_req = 1; mem_unsec = 1; aw_cnt = 0;
    fail_count = 0; checks = 0; nv_opt = 8'ha1; nv_prot = 8'hf0;
    do_reset();
    apb(0, 8'h00, 0, 0);
    chk("options", rd, 32'h0000_00a1);
    chk("secure", 32'(sec), 1);
    chk("redirect", 32'(redir), 1);
    chk("deny", 32'(deny), 1);
    apb(1, 8'h00, 32'h0000_0002, 0);
    apb(0, 8'h00, 0, 0);
    chk("options_ro", rd, 32'h0000_00a1);
    apb(0, 8'h08, 0, 0);
    chk("protect", rd, 32'h0000_00f0);
    apb(1, 8'h08, 32'h0000_00e0, 0);
    apb(1, 8'h08, 32'h0000_00f0, 0);
    apb(0, 8'h08, 0, 0);
    chk("protect_grow", rd, 32'h0000_00e0);
    chk("select", 32'(psel7), 32'h70);
    cmd(16'he1ff, 0, 1, 0);
    cmd(16'he200, 0, 0, 1);
    cmd(16'h0000, 1, 0, 1);
    apb(0, 8'h0c, 0, 0);
    chk("violation", rd & 32'h0000_0020, 32'h0000_0020);
    chk("status_secure", rd & 32'h0000_0001, 32'h0000_0001);
    apb(1, 8'h0c, 32'h0000_0020, 0);
    apb(0, 8'h0c, 0, 0);
    chk("violation_clear", rd & 32'h0000_0020, 32'h0000_0000);
    apb(1, 8'h08, 32'h0000_0001, 1);
    chk("disable", 32'(pdis), 1);
    cmd(16'hffff, 0, 1, 0);
    apb(1, 8'h08, 32'h0000_0000, 0);
    apb(0, 8'h08, 0, 0);
    chk("protect_frozen", rd, 32'h0000_0001);
    apb(0, 8'h10, 0, 0);
    chk("unmapped", 32'(err), 1);
    u_fw.send_key(KEY, 0);
    repeat (2) @(posedge clk);
    chk("array_writes", 32'(aw_cnt), 8);
    chk("array_addr", 32'(aa), 32'h0000_ffb7);
    chk("array_data", 32'(adat), 32'h0000_0001);
    key_try(~KEY, 0);
    chk("wrong_key", 32'(sec), 1);
    key_try(KEY, 1);
    chk("debug_key", 32'(sec), 1);
    chk("debug_key_arr", 32'(aw_cnt), 8);
    key_try(KEY, 0);
    chk("unlock", 32'(sec), 0);
    chk("gate_open", 32'(deny), 0);
    apb(0, 8'h00, 0, 0);
    chk("sec_code", rd, 32'h0000_00a2);
    nv_opt <= 8'h41;
    do_reset();
    chk("relock", 32'(sec), 1);
    chk("no_redirect", 32'(redir), 0);
    key_try(KEY, 0);
    chk("keys_off", 32'(sec), 1);
    mem_unsec <= 1'b0;
    blank_ok <= 1'b1;
    @(posedge clk);
    blank_ok <= 1'b0;
    repeat (4) @(negedge clk);
    chk("blank_unlock", 32'(sec), 0);
    report_and_stop();
  end
endmodule : tb_flash_security_protection_opts
